// ---- design/ssrs_map.svh ----
// Constant map for the sensor serial register select block
`ifndef SSRS_MAP_SVH
`define SSRS_MAP_SVH
`define SSRS_CLK_HZ 20000000
`define SSRS_STALL_MS 35
`define SSRS_STALL_CYC ((`SSRS_STALL_MS * `SSRS_CLK_HZ) / 1000)
`define SSRS_ADDR_BASE 7'h48
`define SSRS_STRAP_GND 2'h0
`define SSRS_STRAP_VCC 2'h1
`define SSRS_STRAP_SDA 2'h2
`define SSRS_BYTE_BITS 4'h8
`define SSRS_PTR_TEMP 2'h0
`define SSRS_PTR_CONF 2'h1
`define SSRS_PTR_LOW 2'h2
`define SSRS_PTR_HIGH 2'h3
`define SSRS_PTR_RESET 8'h00
`define SSRS_CONF_RESET 16'h2610
`define SSRS_LOW_RESET 16'h4b00
`define SSRS_HIGH_RESET 16'h5000
`define SSRS_TEMP_MASK 16'hfff0
`endif

// ---- design/ssrs_pkg.sv ----
// Types for the sensor serial register select block
package ssrs_pkg;
   typedef enum logic [2:0] {
      SSRS_IDLE, SSRS_ADDR, SSRS_PTR, SSRS_WDATA, SSRS_RDATA, SSRS_IGNORE
   } ssrs_state_t;
   typedef struct packed {
      logic scl;
      logic sda;
   } ssrs_bus_in_t;
   typedef struct packed {
      logic sda_out;
      logic sda_oe;
   } ssrs_bus_out_t;
endpackage : ssrs_pkg

// ---- design/ssrs_target.sv ----
// Two-wire target: stall timeout, address strap and register pointer
`include "ssrs_map.svh"

// What this block does
// - Clock held low past the stall limit resets the interface and frees data.
// - Stall counting runs only with clock low inside a START-STOP transaction.
// - Strap to ground, supply or data line gives one of three addresses.
// - Host writes an 8-bit pointer; later accesses go to the selected register.
// - Pointer 00 temperature RO, 01 configuration, 10 low, 11 high limit.
// - Reset clears the pointer so plain reads return the temperature.
module ssrs_target (
   input wire logic clk,
   input wire logic srst,
   input wire ssrs_pkg::ssrs_bus_in_t bus_in,
   output ssrs_pkg::ssrs_bus_out_t bus_out,
   input wire logic [1:0] address_strap_input,
   input wire logic [15:0] temperature_in,
   output logic [15:0] configuration_control,
   output logic [15:0] low_limit_threshold,
   output logic [15:0] high_limit_threshold,
   output logic [7:0] register_select_pointer,
   output logic busy
);
   import ssrs_pkg::*;

   // Target address for the strap setting
   function automatic logic [6:0] strap_addr(input logic [1:0] s);
      unique case (s)
         `SSRS_STRAP_VCC: strap_addr = `SSRS_ADDR_BASE + 7'h1;
         `SSRS_STRAP_SDA: strap_addr = `SSRS_ADDR_BASE + 7'h2;
         default: strap_addr = `SSRS_ADDR_BASE;
      endcase
   endfunction : strap_addr

   logic scl_q, sda_q;
   ssrs_state_t state, next_state;
   logic [3:0] bitcnt, next_bitcnt;
   logic [7:0] shreg, next_shreg;
   logic [15:0] rdword, next_rdword;
   logic [7:0] wbyte0, next_wbyte0;
   logic byteno, next_byteno;
   logic ack_phase, next_ack_phase;
   logic in_txn, next_in_txn;
   logic [19:0] stall, next_stall;
   logic sda_out_q, next_sda_out;
   logic [7:0] next_ptr;
   logic [15:0] next_conf, next_low, next_high;
   logic start_c, stop_c, rise, fall, timeout;

   assign start_c = scl_q && bus_in.scl && sda_q && !bus_in.sda;
   assign stop_c = scl_q && bus_in.scl && !sda_q && bus_in.sda;
   assign rise = !scl_q && bus_in.scl;
   assign fall = scl_q && !bus_in.scl;
   assign timeout = (stall >= 20'(`SSRS_STALL_CYC));
   assign busy = in_txn;
   // Open-drain data: only the enable moves
   assign bus_out = '{sda_out: 1'b0, sda_oe: sda_out_q};

   // Selected register contents for reads
   function automatic logic [15:0] sel_reg(input logic [1:0] p, input logic [15:0] t,
         input logic [15:0] c, input logic [15:0] l, input logic [15:0] h);
      unique case (p)
         `SSRS_PTR_TEMP: sel_reg = t & `SSRS_TEMP_MASK;
         `SSRS_PTR_CONF: sel_reg = c;
         `SSRS_PTR_LOW: sel_reg = l;
         default: sel_reg = h;
      endcase
   endfunction : sel_reg

   // Next-state logic of the serial engine
   always_comb begin
      next_state = state;
      next_bitcnt = bitcnt;
      next_shreg = shreg;
      next_rdword = rdword;
      next_wbyte0 = wbyte0;
      next_byteno = byteno;
      next_ack_phase = ack_phase;
      next_in_txn = in_txn;
      next_sda_out = sda_out_q;
      next_ptr = register_select_pointer;
      next_conf = configuration_control;
      next_low = low_limit_threshold;
      next_high = high_limit_threshold;
      if (in_txn && !bus_in.scl) begin
         next_stall = timeout ? stall : stall + 20'h1;
      end else begin
         next_stall = 20'h0;
      end
      if (rise && !ack_phase) begin
         next_shreg = {shreg[6:0], bus_in.sda};
         next_bitcnt = bitcnt + 4'h1;
      end
      if (fall) begin
         if (ack_phase) begin
            next_ack_phase = 1'b0;
            next_sda_out = 1'b0;
            next_bitcnt = 4'h0;
            if (state == SSRS_RDATA && shreg[0]) begin
               // Host NACK ends the read
               next_state = SSRS_IGNORE;
            end else if (state == SSRS_RDATA) begin
               next_sda_out = !rdword[15];
               next_rdword = {rdword[14:0], 1'b0};
            end
         end else if (bitcnt == `SSRS_BYTE_BITS) begin
            next_ack_phase = 1'b1;
            next_sda_out = 1'b0;
            unique case (state)
               SSRS_ADDR: begin
                  if (shreg[7:1] == strap_addr(address_strap_input)) begin
                     next_sda_out = 1'b1;
                     next_byteno = 1'b0;
                     if (shreg[0]) begin
                        next_state = SSRS_RDATA;
                        next_rdword = sel_reg(register_select_pointer[1:0], temperature_in,
                           configuration_control, low_limit_threshold, high_limit_threshold);
                     end else begin
                        next_state = SSRS_PTR;
                     end
                  end else begin
                     next_state = SSRS_IGNORE;
                  end
               end
               SSRS_PTR: begin
                  next_ptr = shreg;
                  next_sda_out = 1'b1;
                  next_state = SSRS_WDATA;
               end
               SSRS_WDATA: begin
                  next_sda_out = 1'b1;
                  next_byteno = !byteno;
                  if (!byteno) begin
                     next_wbyte0 = shreg;
                  end else begin
                     unique case (register_select_pointer[1:0])
                        `SSRS_PTR_CONF: next_conf = {wbyte0, shreg};
                        `SSRS_PTR_LOW: next_low = {wbyte0, shreg};
                        `SSRS_PTR_HIGH: next_high = {wbyte0, shreg};
                        default: next_high = high_limit_threshold;
                     endcase
                  end
               end
               SSRS_RDATA: begin
                  // Line freed for the host's acknowledge bit
                  next_sda_out = 1'b0;
               end
               default: next_state = state;
            endcase
         end else if (state == SSRS_RDATA && bitcnt < `SSRS_BYTE_BITS) begin
            next_sda_out = !rdword[15];
            next_rdword = {rdword[14:0], 1'b0};
         end else if (state == SSRS_RDATA) begin
            next_sda_out = 1'b0;
         end
      end
      if (state == SSRS_RDATA && rise && ack_phase) begin
         next_shreg = {7'h0, bus_in.sda};
      end
      if (start_c) begin
         next_in_txn = 1'b1;
         next_state = SSRS_ADDR;
         next_bitcnt = 4'h0;
         next_ack_phase = 1'b0;
         next_sda_out = 1'b0;
      end
      // stall or stop frees the line
      if (stop_c || timeout) begin
         next_in_txn = 1'b0;
         next_state = SSRS_IDLE;
         next_sda_out = 1'b0;
         next_ack_phase = 1'b0;
         next_bitcnt = 4'h0;
      end
   end

   // Registers of the serial engine
   always_ff @(posedge clk) begin
      if (srst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         state <= SSRS_IDLE;
         bitcnt <= 4'h0;
         shreg <= 8'h0;
         rdword <= 16'h0;
         wbyte0 <= 8'h0;
         byteno <= 1'b0;
         ack_phase <= 1'b0;
         in_txn <= 1'b0;
         stall <= 20'h0;
         sda_out_q <= 1'b0;
         register_select_pointer <= `SSRS_PTR_RESET;
         configuration_control <= `SSRS_CONF_RESET;
         low_limit_threshold <= `SSRS_LOW_RESET;
         high_limit_threshold <= `SSRS_HIGH_RESET;
      end else begin
         scl_q <= bus_in.scl;
         sda_q <= bus_in.sda;
         state <= next_state;
         bitcnt <= next_bitcnt;
         shreg <= next_shreg;
         rdword <= next_rdword;
         wbyte0 <= next_wbyte0;
         byteno <= next_byteno;
         ack_phase <= next_ack_phase;
         in_txn <= next_in_txn;
         stall <= next_stall;
         sda_out_q <= next_sda_out;
         register_select_pointer <= next_ptr;
         configuration_control <= next_conf;
         low_limit_threshold <= next_low;
         high_limit_threshold <= next_high;
      end
   end

   // Stall releases data line next cycle
   stall_release_a: assert property (@(posedge clk) disable iff (srst)
      timeout |=> !bus_out.sda_oe && state == SSRS_IDLE)
      else $error("stall did not release the data line");
   // No counting while idle
   idle_no_count_a: assert property (@(posedge clk) disable iff (srst)
      !in_txn |=> stall == 20'h0)
      else $error("stall counter ran outside a transaction");
   // Counter grows with clock held low
   low_count_a: assert property (@(posedge clk) disable iff (srst)
      in_txn && !bus_in.scl && !timeout && !stop_c |=> stall == $past(stall) + 20'h1)
      else $error("stall counter did not advance");
   // Pointer moves only at a pointer byte
   ptr_write_a: assert property (@(posedge clk) disable iff (srst)
      register_select_pointer != $past(register_select_pointer) |-> $past(state) == SSRS_PTR)
      else $error("pointer changed outside a pointer write");
   // Temperature never written
   temp_ro_a: assert property (@(posedge clk) disable iff (srst)
      register_select_pointer[1:0] == `SSRS_PTR_TEMP |=> $stable(configuration_control)
         && $stable(low_limit_threshold) && $stable(high_limit_threshold))
      else $error("write reached a register with temperature selected");
   // Pointer low after reset
   ptr_reset_a: assert property (@(posedge clk)
      srst |=> register_select_pointer == `SSRS_PTR_RESET)
      else $error("pointer not cleared by reset");
   // Pointer survives a stop
   ptr_keep_a: assert property (@(posedge clk) disable iff (srst)
      stop_c |=> $stable(register_select_pointer))
      else $error("pointer lost at stop");
   // Ack only for strapped address
   addr_ack_a: assert property (@(posedge clk) disable iff (srst)
      state == SSRS_ADDR && fall && bitcnt == `SSRS_BYTE_BITS && !stop_c && !timeout && !start_c
         && shreg[7:1] != strap_addr(address_strap_input) |=> !bus_out.sda_oe)
      else $error("acknowledged a foreign address");
endmodule : ssrs_target

// ---- verification/ssrs_host.sv ----
// Two-wire host model that drives the target's clock and data lines
module ssrs_host (
   input wire logic clk,
   input wire ssrs_pkg::ssrs_bus_out_t bus_out,
   output ssrs_pkg::ssrs_bus_in_t bus_in
);
   timeunit 1ns;
   timeprecision 1ns;
   import ssrs_pkg::*;
   logic scl_q = 1'b1;
   logic sda_q = 1'b1;
   // Data wire is open drain with a pull-up
   assign bus_in = '{scl: scl_q, sda: sda_q & ~bus_out.sda_oe};
   // One bus phase, changed just after an edge
   task automatic hp(input logic s, input logic d);
      @(posedge clk);
      scl_q <= s;
      sda_q <= d;
      repeat (4) @(posedge clk);
   endtask : hp
   task automatic start();
      hp(1'b1, 1'b1);
      hp(1'b1, 1'b0);
   endtask : start
   task automatic stop();
      hp(1'b0, sda_q);
      hp(1'b0, 1'b0);
      hp(1'b1, 1'b0);
      hp(1'b1, 1'b1);
   endtask : stop
   task automatic xfer(input logic [8:0] d, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         hp(1'b0, sda_q);
         hp(1'b0, d[i]);
         hp(1'b1, d[i]);
         r[i] = bus_in.sda;
      end
   endtask : xfer
endmodule : ssrs_host

// ---- verification/sensor_serial_register_select_tb.sv ----
// Self-checking bench for the sensor serial register select block
`include "ssrs_map.svh"
module sensor_serial_register_select_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ssrs_pkg::*;
   typedef struct {logic [7:0] p; logic [15:0] d; logic [15:0] e;} ssrs_row_t;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [1:0] address_strap_input = 2'h0;
   logic [15:0] temperature_in = 16'h1234;
   ssrs_bus_in_t bus_in;
   ssrs_bus_out_t bus_out;
   logic [15:0] conf, lowl, highl, v;
   logic [7:0] ptr;
   logic [8:0] r;
   logic busy;
   logic [6:0] base = `SSRS_ADDR_BASE;
   int fails = 0;
   int checks = 0;
   ssrs_row_t rows [4] = '{'{8'h01, 16'ha5c3, 16'ha5c3}, '{8'h02, 16'h1e70, 16'h1e70},
      '{8'h03, 16'h7ff0, 16'h7ff0}, '{8'h00, 16'hbeef, 16'h1230}};
   ssrs_target dut (.clk(clk), .srst(srst), .bus_in(bus_in), .bus_out(bus_out),
      .address_strap_input(address_strap_input), .temperature_in(temperature_in),
      .configuration_control(conf), .low_limit_threshold(lowl),
      .high_limit_threshold(highl), .register_select_pointer(ptr), .busy(busy));
   ssrs_host host (.clk(clk), .bus_out(bus_out), .bus_in(bus_in));
   // Clock of 50 ns
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      checks++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic chkb(input string n, input logic e, input logic s);
      chk(n, {15'h0, e}, {15'h0, s});
   endtask : chkb
   task automatic stop_test();
      $display("fails %0d checks %0d", fails, checks);
      if (fails == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test
   // Address phase with expected ack
   task automatic addr(input logic [6:0] a, input logic rw, input logic ack);
      host.start();
      host.xfer({a, rw, 1'b1}, r);
      chkb("ack", ~ack, r[0]);
   endtask : addr
   task automatic wr(input logic [7:0] p, input logic [15:0] d, input logic dat);
      addr(base, 1'b0, 1'b1);
      host.xfer({p, 1'b1}, r);
      if (dat) begin
         host.xfer({d[15:8], 1'b1}, r);
         host.xfer({d[7:0], 1'b1}, r);
      end
      host.stop();
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [15:0] d);
      addr(a, 1'b1, 1'b1);
      host.xfer({8'hff, 1'b0}, r);
      d[15:8] = r[8:1];
      host.xfer(9'h1ff, r);
      d[7:0] = r[8:1];
      host.stop();
   endtask : rd
   // Watchdog against a hung bus
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      stop_test();
   end
   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      chk("pointer", 16'h0000, {8'h00, ptr});
      chk("conf", `SSRS_CONF_RESET, conf);
      chk("low", `SSRS_LOW_RESET, lowl);
      chk("high", `SSRS_HIGH_RESET, highl);
      chkb("busy", 1'b0, busy);
      rd(base, v);
      chk("read", 16'h1230, v);
      // Table of register write then read back
      foreach (rows[i]) begin
         wr(rows[i].p, rows[i].d, 1'b1);
         rd(base, v);
         chk("read", rows[i].e, v);
      end
      chk("conf", 16'ha5c3, conf);
      chk("low", 16'h1e70, lowl);
      chk("high", 16'h7ff0, highl);
      wr(8'h02, 16'h0000, 1'b0);
      rd(base, v);
      chk("read", 16'h1e70, v);
      rd(base, v);
      chk("read", 16'h1e70, v);
      addr(base + 7'h1, 1'b0, 1'b0);
      chkb("busy", 1'b1, busy);
      host.stop();
      chkb("busy", 1'b0, busy);
      // Every strap choice answers its own address
      for (int s = 0; s < 3; s++) begin
         @(posedge clk);
         address_strap_input <= s[1:0];
         rd(base + 7'(s), v);
         chk("read", 16'h1e70, v);
      end
      // Reset in mid-run clears a nonzero pointer
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      chk("pointer", 16'h0000, {8'h00, ptr});
      chk("conf", `SSRS_CONF_RESET, conf);
      // New temperature reads back with its low bits masked
      temperature_in <= 16'hc90f;
      rd(base + 7'h2, v);
      chk("read", 16'hc900, v);
      stop_test();
   end
endmodule : sensor_serial_register_select_tb
